//--- hw/protection_supervisor.sv
/*
  Protection and supervision sequencer: supply lockout, brown-in and
  brown-out, fault reactions, auto-restart and latched shutdown, peak
  current limiting and the serial configuration port window.
  Assumes comparator and fault flags synchronous to clk, an APB master and
  a reset derived from the supply.
*/
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
`include "protection_supervisor_regs.svh"

// How it works
// - Serial port open until supply brown-in
// - Keep-alive before brown-in keeps port open
// - Faults judged only while switching
// - Listed faults enter auto-restart
// - Output overvoltage selectable; brown-in blocks, brown-out stops
// - Auto-restart stops gate, enters standby
// - Three seconds off, then recharge, soft-start
// - Startup cell hysteretic during auto-restart
// - Latched shutdown: gate off, wider cell swing
// - Lockout on above 20.5, off 7.2/9.6
// - Supply on/off comparators spike blanked
// - Soft-start needs line and supply brown-in
// - Brown-in acts without blanking
// - Brown-in unmet: standby, no pulses
// - Brown-out after 1.09/5.27 ms low line
// - Peak trip ends pulse after blanking
// - Peak limit compensated, 402mV at low line
module protection_supervisor
  import protection_supervisor_pkg::*;
#(
  parameter int AR_CYCLES = `AR_CYCLES,
  parameter int BO_NORM_CYCLES = `BO_NORM_CYCLES,
  parameter int BO_SS_CYCLES = `BO_SS_CYCLES,
  parameter int SOFTSTART_CYCLES = `SOFTSTART_CYCLES,
  parameter int VCC_BLANK_CYCLES = `VCC_BLANK_CYCLES,
  parameter int LEB_CYCLES = `LEB_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire protection_supervisor_pkg::sense_t sense,
  input wire protection_supervisor_pkg::fault_t faults,
  input wire logic pwmStart,
  input wire logic pwmStop,
  input wire logic peakCurrentTrip,
  output logic mainGateOutput,
  output logic startupCellOn,
  output logic serialPortEnable,
  output logic measureEnable,
  output logic [`PEAK_W-1:0] peakLimitCode
);
  import protection_supervisor_pkg::*;

  localparam int TW = 32;

  if (AR_CYCLES < 1 || BO_NORM_CYCLES < 1 || BO_SS_CYCLES < 1 || SOFTSTART_CYCLES < 1
      || VCC_BLANK_CYCLES < 1 || LEB_CYCLES < 1 || LEB_CYCLES > 255) begin : g_bad_counts
    $error("protection_supervisor counts must be at least 1");
  end

  function automatic logic isSwitching(input seq_state_t s);
    isSwitching = (s == ST_SOFTSTART) || (s == ST_RUN);
  endfunction

  seq_state_t state_ff, nxt_state;
  logic [TW-1:0] timer_ff, nxt_timer;
  logic arDone_ff, nxt_arDone;
  logic gate_ff, nxt_gate;
  logic [7:0] leb_ff, nxt_leb;
  logic cell_ff, nxt_cell;
  logic boFlag_ff, nxt_boFlag;
  logic biSeen_ff, nxt_biSeen;
  logic keepAlive_ff, nxt_keepAlive;
  logic voutLatch_ff, nxt_voutLatch;
  logic [`PEAK_W-1:0] peakHigh_ff, nxt_peakHigh;
  logic [`PEAK_W-1:0] peak_ff, nxt_peak;
  logic port_ff, nxt_port;
  logic measure_ff, nxt_measure;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic supplyOnQ, supplyOffQ, brownoutQ;
  logic offLevel, arFault, lebDone, wrEn;
  logic [TW-1:0] boLimit;

  // Supply turn-on and turn-off spike blanking
  blank_filter #(.WIDTH(TW)) u_on_blank (
    .clk(clk),
    .rst_b(rst_b),
    .level(sense.supplyAboveOn),
    .limit(TW'(VCC_BLANK_CYCLES)),
    .qualified(supplyOnQ)
  );

  // Off threshold rises to the brown-out level once brown-out is declared
  assign offLevel = boFlag_ff ? sense.supplyBelowOffBo : sense.supplyBelowOff;

  blank_filter #(.WIDTH(TW)) u_off_blank (
    .clk(clk),
    .rst_b(rst_b),
    .level(offLevel && (state_ff != ST_OFF)),
    .limit(TW'(VCC_BLANK_CYCLES)),
    .qualified(supplyOffQ)
  );

  // Brown-out blanking, longer during soft-start
  assign boLimit = (state_ff == ST_SOFTSTART) ? TW'(BO_SS_CYCLES) : TW'(BO_NORM_CYCLES);

  blank_filter #(.WIDTH(TW)) u_bo_blank (
    .clk(clk),
    .rst_b(rst_b),
    .level(sense.lineBelowBrownout && isSwitching(state_ff)),
    .limit(boLimit),
    .qualified(brownoutQ)
  );

  assign arFault = faults.secondLevelOvercurrent || faults.supplyOvervoltageFault
    || faults.feedbackHighFault || faults.dieOvertempFault
    || faults.overloadFault || faults.sensePinShortFault;

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_arDone = arDone_ff;
    case (state_ff)
      ST_OFF: begin
        if (supplyOnQ) begin
          nxt_state = ST_WAIT_BI;
        end
      end
      ST_WAIT_BI: begin
        if (sense.lineAboveBrownin && sense.supplyAboveBrownin) begin
          nxt_state = ST_SOFTSTART;
          nxt_timer = '0;
        end
      end
      ST_SOFTSTART, ST_RUN: begin
        if (state_ff == ST_SOFTSTART) begin
          nxt_timer = timer_ff + 1'b1;
          if (timer_ff >= TW'(SOFTSTART_CYCLES - 1)) begin
            nxt_state = ST_RUN;
          end
        end
        if (faults.outputOvervoltageFault && voutLatch_ff) begin
          nxt_state = ST_LATCHED;
        end else if (arFault || faults.outputOvervoltageFault) begin
          nxt_state = ST_AUTORESTART;
          nxt_timer = '0;
          nxt_arDone = 1'b0;
        end else if (brownoutQ) begin
          nxt_state = ST_BROWNOUT;
        end
      end
      ST_AUTORESTART: begin
        if (!arDone_ff) begin
          nxt_timer = timer_ff + 1'b1;
          if (timer_ff >= TW'(AR_CYCLES - 1)) begin
            nxt_arDone = 1'b1;
          end
        end else if (supplyOnQ) begin
          nxt_state = ST_WAIT_BI;
        end
      end
      ST_LATCHED, ST_BROWNOUT: begin
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (supplyOffQ && (state_ff != ST_OFF)) begin
      nxt_state = ST_OFF;
    end
  end

  // Gate pulse with leading-edge blanking
  always_comb begin
    nxt_gate = gate_ff;
    nxt_leb = leb_ff;
    if (gate_ff && (leb_ff < 8'(LEB_CYCLES))) begin
      nxt_leb = leb_ff + 1'b1;
    end
    if (gate_ff && ((lebDone && peakCurrentTrip) || pwmStop)) begin
      nxt_gate = 1'b0;
    end else if (!gate_ff && pwmStart) begin
      nxt_gate = 1'b1;
      nxt_leb = '0;
    end
    if (!isSwitching(nxt_state)) begin
      nxt_gate = 1'b0;
    end
  end

  assign lebDone = (leb_ff >= 8'(LEB_CYCLES));

  // Startup cell, measurement enable, peak limit and port window
  always_comb begin
    nxt_cell = cell_ff;
    nxt_boFlag = boFlag_ff;
    nxt_biSeen = biSeen_ff;
    case (nxt_state)
      ST_OFF: begin
        nxt_cell = 1'b1;
      end
      ST_AUTORESTART: begin
        if (!sense.supplyAboveBrownin) begin
          nxt_cell = 1'b1;
        end else if (sense.supplyAboveOn) begin
          nxt_cell = 1'b0;
        end
      end
      ST_LATCHED: begin
        if (sense.supplyBelowOffBo) begin
          nxt_cell = 1'b1;
        end else if (sense.supplyAboveOn) begin
          nxt_cell = 1'b0;
        end
      end
      default: begin
        nxt_cell = 1'b0;
      end
    endcase
    if (nxt_state == ST_BROWNOUT) begin
      nxt_boFlag = 1'b1;
    end else if (nxt_state == ST_OFF) begin
      nxt_boFlag = 1'b0;
    end
    if ((state_ff == ST_WAIT_BI) && sense.supplyAboveBrownin) begin
      nxt_biSeen = 1'b1;
    end
    nxt_port = !nxt_biSeen || nxt_keepAlive;
    nxt_measure = isSwitching(nxt_state);
    nxt_peak = sense.lowLine ? `PEAK_MAX_MV : peakHigh_ff;
  end

  // APB slave, no wait states, errors on unmapped offsets
  assign wrEn = psel && penable && pwrite && pready_ff;

  always_comb begin
    nxt_keepAlive = keepAlive_ff;
    nxt_voutLatch = voutLatch_ff;
    nxt_peakHigh = peakHigh_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = psel && !penable;
    nxt_pslverr = 1'b0;
    if (wrEn && (paddr == `REG_CTRL)) begin
      nxt_voutLatch = pwdata[`CTRL_VOUT_LATCH];
      if (!biSeen_ff && pwdata[`CTRL_KEEP_ALIVE]) begin
        nxt_keepAlive = 1'b1;
      end
    end
    if (wrEn && (paddr == `REG_PEAK) && port_ff) begin
      nxt_peakHigh = pwdata[`PEAK_W-1:0];
    end
    if (psel && !penable) begin
      nxt_prdata = '0;
      case (paddr)
        `REG_CTRL: begin
          nxt_prdata[`CTRL_VOUT_LATCH] = voutLatch_ff;
          nxt_prdata[`CTRL_KEEP_ALIVE] = keepAlive_ff;
        end
        `REG_STATUS: begin
          nxt_prdata[`STAT_STATE_LSB +: 3] = state_ff;
          nxt_prdata[`STAT_GATE] = gate_ff;
          nxt_prdata[`STAT_CELL] = cell_ff;
          nxt_prdata[`STAT_PORT] = port_ff;
          nxt_prdata[`STAT_BO] = boFlag_ff;
          nxt_prdata[`STAT_BI_SEEN] = biSeen_ff;
          nxt_prdata[`STAT_MEASURE] = measure_ff;
        end
        `REG_PEAK: begin
          nxt_prdata[`PEAK_W-1:0] = peakHigh_ff;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_OFF;
      timer_ff <= '0;
      arDone_ff <= 1'b0;
      gate_ff <= 1'b0;
      leb_ff <= '0;
      cell_ff <= 1'b1;
      boFlag_ff <= 1'b0;
      biSeen_ff <= 1'b0;
      keepAlive_ff <= 1'b0;
      voutLatch_ff <= 1'b0;
      peakHigh_ff <= `PEAK_HIGH_DEF_MV;
      peak_ff <= `PEAK_MAX_MV;
      port_ff <= 1'b1;
      measure_ff <= 1'b0;
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      arDone_ff <= nxt_arDone;
      gate_ff <= nxt_gate;
      leb_ff <= nxt_leb;
      cell_ff <= nxt_cell;
      boFlag_ff <= nxt_boFlag;
      biSeen_ff <= nxt_biSeen;
      keepAlive_ff <= nxt_keepAlive;
      voutLatch_ff <= nxt_voutLatch;
      peakHigh_ff <= nxt_peakHigh;
      peak_ff <= nxt_peak;
      port_ff <= nxt_port;
      measure_ff <= nxt_measure;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mainGateOutput = gate_ff;
  assign startupCellOn = cell_ff;
  assign serialPortEnable = port_ff;
  assign measureEnable = measure_ff;
  assign peakLimitCode = peak_ff;

  a_port_closes: assert property (@(posedge clk) disable iff (!rst_b)
    (biSeen_ff && !keepAlive_ff) |-> !port_ff)
    else $error("serial port open after brown-in");

  a_port_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (keepAlive_ff && isSwitching(state_ff)) |-> port_ff)
    else $error("keep-alive port closed");

  a_sleep_measure: assert property (@(posedge clk) disable iff (!rst_b)
    !isSwitching(state_ff) |-> (!measure_ff && !gate_ff))
    else $error("measurement or gate active while asleep");

  a_fault_restart: assert property (@(posedge clk) disable iff (!rst_b)
    (isSwitching(state_ff) && arFault && !faults.outputOvervoltageFault && !supplyOffQ)
    |=> (state_ff == ST_AUTORESTART) && !gate_ff && !measure_ff)
    else $error("fault did not enter auto-restart");

  a_vout_latch: assert property (@(posedge clk) disable iff (!rst_b)
    (isSwitching(state_ff) && faults.outputOvervoltageFault && !supplyOffQ)
    |=> (state_ff == ($past(voutLatch_ff) ? ST_LATCHED : ST_AUTORESTART)))
    else $error("output overvoltage reaction wrong");

  a_restart_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_ff == ST_AUTORESTART) && !arDone_ff && !supplyOffQ) |=> (state_ff == ST_AUTORESTART))
    else $error("auto-restart left before off-time");

  a_restart_cell: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_ff == ST_AUTORESTART) && !arDone_ff && !supplyOffQ && !sense.supplyAboveBrownin)
    |=> cell_ff)
    else $error("startup cell not recharging in auto-restart");

  a_latch_cell: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_ff == ST_LATCHED) && !supplyOffQ && sense.supplyBelowOffBo) |=> cell_ff ##1 !gate_ff)
    else $error("latched supply not held");

  a_lockout_off: assert property (@(posedge clk) disable iff (!rst_b)
    (supplyOffQ && (state_ff != ST_OFF)) |=> (state_ff == ST_OFF) && cell_ff)
    else $error("lockout did not deactivate");

  a_brownin_start: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_ff == ST_WAIT_BI) && sense.lineAboveBrownin && sense.supplyAboveBrownin && !supplyOffQ)
    |=> (state_ff == ST_SOFTSTART))
    else $error("brown-in did not start soft-start");

  a_peak_end: assert property (@(posedge clk) disable iff (!rst_b)
    (gate_ff && lebDone && peakCurrentTrip) |=> !gate_ff)
    else $error("peak trip did not end pulse");

  a_peak_low: assert property (@(posedge clk) disable iff (!rst_b)
    sense.lowLine |=> (peak_ff == `PEAK_MAX_MV))
    else $error("low line peak limit wrong");

endmodule

//--- hw/protection_supervisor_regs.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  protection supervisor.
  Assumes a 10 MHz system clock and an APB slave with 32-bit data.
*/
`ifndef PROTECTION_SUPERVISOR_REGS_SVH
`define PROTECTION_SUPERVISOR_REGS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PEAK 8'h08

// Control fields
`define CTRL_VOUT_LATCH 0
`define CTRL_KEEP_ALIVE 1

// Status fields
`define STAT_STATE_LSB 0
`define STAT_GATE 3
`define STAT_CELL 4
`define STAT_PORT 5
`define STAT_BO 6
`define STAT_BI_SEEN 7
`define STAT_MEASURE 8

// Peak limit setting, millivolt code
`define PEAK_W 10
`define PEAK_MAX_MV 10'h192
`define PEAK_HIGH_DEF_MV 10'h170

// Timing
`define CLK_PERIOD_NS 100
`define AR_TIME_MS 3000
`define BO_NORM_TIME_US 1090
`define BO_SS_TIME_US 5270
`define SOFTSTART_TIME_US 10000
`define AR_CYCLES (`AR_TIME_MS * (1000000 / `CLK_PERIOD_NS))
`define BO_NORM_CYCLES ((`BO_NORM_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BO_SS_CYCLES ((`BO_SS_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFTSTART_CYCLES ((`SOFTSTART_TIME_US * 1000) / `CLK_PERIOD_NS)
`define VCC_BLANK_CYCLES 16
`define LEB_CYCLES 3

`endif

//--- hw/protection_supervisor_pkg.sv
/*
  Types of the protection supervisor: sequencer states and grouped inputs.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package protection_supervisor_pkg;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WAIT_BI = 3'b001,
    ST_SOFTSTART = 3'b010,
    ST_RUN = 3'b011,
    ST_AUTORESTART = 3'b100,
    ST_LATCHED = 3'b101,
    ST_BROWNOUT = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic supplyAboveOn;
    logic supplyBelowOff;
    logic supplyBelowOffBo;
    logic supplyAboveBrownin;
    logic lineAboveBrownin;
    logic lineBelowBrownout;
    logic lowLine;
  } sense_t;

  typedef struct packed {
    logic secondLevelOvercurrent;
    logic supplyOvervoltageFault;
    logic feedbackHighFault;
    logic dieOvertempFault;
    logic overloadFault;
    logic sensePinShortFault;
    logic outputOvervoltageFault;
  } fault_t;

endpackage

//--- hw/blank_filter.sv
/*
  Blanking filter: the output rises once the input has stood high for more than limit
  cycles and falls at once when the input drops, clearing the count.
  Assumes an input synchronous to clk.
*/
`timescale 1ns/100ps
module blank_filter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic level,
  input wire logic [WIDTH-1:0] limit,
  output logic qualified
);

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic qual_ff;
  logic nxt_qual;

  if (WIDTH < 1) begin : g_bad_width
    $error("blank_filter needs WIDTH of at least 1");
  end

  always_comb begin
    nxt_count = count_ff;
    nxt_qual = 1'b0;
    if (!level) begin
      nxt_count = '0;
    end else if (count_ff < limit) begin
      nxt_count = count_ff + 1'b1;
    end
    if (level && (count_ff >= limit)) begin
      nxt_qual = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= '0;
      qual_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      qual_ff <= nxt_qual;
    end
  end

  assign qualified = qual_ff;

endmodule

//--- test/flyback_stage_model.sv
/*
  Behavioural flyback stage: supply, line and current-sense comparators.
  Assumes supervisor outputs on clk; supply in 0.1 V steps, line in uA.
*/
`timescale 1ns/100ps
module flyback_stage_model
  import protection_supervisor_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mainGateOutput,
  input wire logic startupCellOn,
  input wire logic [11:0] lineUa,
  input wire logic lowLineIn,
  input wire logic [7:0] drain,
  input wire logic [3:0] rampLen,
  output protection_supervisor_pkg::sense_t sense,
  output logic peakCurrentTrip,
  output logic [8:0] vcc
);
  logic [3:0] onCnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vcc <= '0;
      onCnt <= '0;
    end else begin
      if (startupCellOn) vcc <= (vcc > 9'd245) ? 9'd250 : vcc + 9'd5;
      else vcc <= (vcc > {1'b0, drain}) ? vcc - {1'b0, drain} : '0;
      onCnt <= mainGateOutput ? onCnt + 4'h1 : 4'h0;
    end
  end
  // Current ramp reaches the limit rampLen cycles into the pulse
  assign peakCurrentTrip = mainGateOutput && (onCnt >= rampLen);
  assign sense = '{vcc > 9'd205, vcc < 9'd72, vcc < 9'd96, vcc > 9'd150,
    lineUa > 12'd1150, lineUa < 12'd443, lowLineIn};
endmodule

//--- test/test_protection_supervisor.sv
/*
  Self-checking bench of the protection supervisor.
  Assumes the flyback stage model and the supervisor package and header.
*/
`timescale 1ns/100ps
`include "protection_supervisor_regs.svh"
module test_protection_supervisor;
  import protection_supervisor_pkg::*;
  typedef struct {
    logic [1:0] sel;
    logic [31:0] mask;
    logic [31:0] val;
  } note_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sense_t sense;
  fault_t faults = '0;
  logic pwmStart = 1'b0;
  logic pwmStop = 1'b0;
  logic peakCurrentTrip;
  logic mainGateOutput;
  logic startupCellOn;
  logic serialPortEnable;
  logic measureEnable;
  logic [`PEAK_W-1:0] peakLimitCode;
  logic [11:0] lineUa = 12'd500;
  logic lowLineIn = 1'b0;
  logic [7:0] drain = 8'h00;
  logic [3:0] rampLen = 4'h1;
  logic [8:0] vcc;
  logic probe = 1'b0;
  logic [16:0] seed = 17'd89247;
  int failures = 0;
  int comparisons = 0;
  note_t notes[$];

  protection_supervisor #(.AR_CYCLES(50), .BO_NORM_CYCLES(20), .BO_SS_CYCLES(40),
    .SOFTSTART_CYCLES(30), .VCC_BLANK_CYCLES(4), .LEB_CYCLES(3)) dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .faults(faults), .pwmStart(pwmStart),
    .pwmStop(pwmStop), .peakCurrentTrip(peakCurrentTrip),
    .mainGateOutput(mainGateOutput), .startupCellOn(startupCellOn),
    .serialPortEnable(serialPortEnable), .measureEnable(measureEnable),
    .peakLimitCode(peakLimitCode));
  flyback_stage_model stage (.clk(clk), .rst_b(rst_b), .mainGateOutput(mainGateOutput),
    .startupCellOn(startupCellOn), .lineUa(lineUa), .lowLineIn(lowLineIn),
    .drain(drain), .rampLen(rampLen), .sense(sense),
    .peakCurrentTrip(peakCurrentTrip), .vcc(vcc));

  always #50 clk = ~clk;

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return measureEnable;
      1: return startupCellOn;
      2: return sense.supplyBelowOffBo;
      default: return sense.supplyBelowOff;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Results are compared in order as they appear
  always @(posedge clk) begin
    note_t nt;
    if ((psel && penable && pready === 1'b1 && !pwrite) || probe) begin
      if (notes.size() == 0) check("queue", 32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        if (probe && nt.sel[0]) check("peak", 32'(peakLimitCode) & nt.mask, nt.val);
        else if (probe) check("pins", 32'({measureEnable, serialPortEnable,
          startupCellOn, mainGateOutput}) & nt.mask, nt.val);
        else begin
          check("read", prdata & nt.mask, nt.val);
          check("error", 32'(pslverr), 32'(nt.sel[1]));
        end
      end
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) check("pready", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
    input logic e = 1'b0);
    notes.push_back('{{e, 1'b0}, m, v});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic look(input logic s, input logic [31:0] m, input logic [31:0] v);
    notes.push_back('{{1'b0, s}, m, v});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wt(input int w, input logic v);
    int n = 0;
    while (pick(w) !== v && n < 3000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 3000) check("wait", 32'h1, 32'h0);
  endtask

  task automatic rst();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  task automatic start(input logic [31:0] ctrl);
    rst();
    drain <= 8'h00;
    lineUa <= 12'd1151 + {3'h0, seed[8:0]};
    seed = lfsr(seed);
    apb(1'b1, `REG_CTRL, ctrl);
    wt(0, 1'b1);
    repeat (40) @(posedge clk);
  endtask

  initial begin
    logic [9:0] pk;
    rst();
    rd(`REG_STATUS, 32'h1ff, 32'h030);
    rd(`REG_PEAK, 32'h3ff, 32'h170);
    rd(8'h0c, 32'hffffffff, 32'h0, 1'b1);
    look(1'b1, 32'h3ff, 32'h170);
    faults <= 7'h04;
    repeat (60) @(posedge clk);
    rd(`REG_STATUS, 32'h10f, 32'h001);
    faults <= '0;
    drain <= 8'd1 + {7'h0, seed[0]};
    seed = lfsr(seed);
    wt(2, 1'b1);
    repeat (8) @(posedge clk);
    rd(`REG_STATUS, 32'h7, 32'h1);
    wt(3, 1'b1);
    repeat (8) @(posedge clk);
    look(1'b0, 32'h2, 32'h2);
    rd(`REG_STATUS, 32'h7, 32'h0);
    $display("test lockout done");
    start(32'h2);
    rd(`REG_STATUS, 32'h1af, 32'h1a3);
    look(1'b0, 32'hd, 32'hc);
    pk = seed[9:0];
    seed = lfsr(seed);
    apb(1'b1, `REG_PEAK, {22'h0, pk});
    rd(`REG_PEAK, 32'h3ff, {22'h0, pk});
    look(1'b1, 32'h3ff, {22'h0, pk});
    lowLineIn <= 1'b1;
    repeat (3) @(posedge clk);
    look(1'b1, 32'h3ff, 32'h192);
    lowLineIn <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      rampLen <= i ? 4'd8 : 4'd1;
      pwmStart <= 1'b1;
      @(posedge clk);
      pwmStart <= 1'b0;
      repeat (i ? 4 : 2) @(posedge clk);
      look(1'b0, 32'h1, 32'h1);
      repeat (i ? 8 : 0) @(posedge clk);
      look(1'b0, 32'h1, 32'h0);
    end
    rampLen <= 4'hf;
    pwmStart <= 1'b1;
    @(posedge clk);
    pwmStart <= 1'b0;
    repeat (4) @(posedge clk);
    look(1'b0, 32'h1, 32'h1);
    pwmStop <= 1'b1;
    @(posedge clk);
    pwmStop <= 1'b0;
    look(1'b0, 32'h1, 32'h0);
    $display("test gate done");
    for (int i = 0; i < 7; i++) begin
      faults <= 7'h1 << i;
      @(posedge clk);
      @(posedge clk);
      look(1'b0, 32'h9, 32'h0);
      faults <= '0;
      drain <= 8'd1;
      rd(`REG_STATUS, 32'hf, 32'h4);
      wt(1, 1'b1);
      wt(1, 1'b0);
      wt(0, 1'b1);
      drain <= 8'h00;
      repeat (40) @(posedge clk);
      rd(`REG_STATUS, 32'h7, 32'h3);
    end
    $display("test restart done");
    apb(1'b1, `REG_CTRL, 32'h3);
    faults <= 7'h01;
    @(posedge clk);
    @(posedge clk);
    look(1'b0, 32'h9, 32'h0);
    faults <= '0;
    drain <= 8'd1;
    rd(`REG_STATUS, 32'hf, 32'h5);
    repeat (80) @(posedge clk);
    look(1'b0, 32'h2, 32'h0);
    wt(1, 1'b1);
    rd(`REG_STATUS, 32'h7, 32'h5);
    $display("test latch done");
    start(32'h0);
    rd(`REG_STATUS, 32'h27, 32'h03);
    look(1'b0, 32'h4, 32'h0);
    apb(1'b1, `REG_PEAK, 32'h55);
    rd(`REG_PEAK, 32'h3ff, 32'h170);
    for (int i = 0; i < 2; i++) begin
      lineUa <= 12'd300;
      repeat (12) @(posedge clk);
      lineUa <= 12'd1200;
      @(posedge clk);
    end
    rd(`REG_STATUS, 32'h7, 32'h3);
    lineUa <= 12'd300;
    repeat (18) @(posedge clk);
    rd(`REG_STATUS, 32'h7, 32'h3);
    repeat (4) @(posedge clk);
    rd(`REG_STATUS, 32'h4f, 32'h46);
    drain <= 8'd1;
    wt(2, 1'b1);
    repeat (10) @(posedge clk);
    rd(`REG_STATUS, 32'h7, 32'h0);
    $display("test brownout done");
    finish_test();
  end

  initial begin
    #(100 * 40000);
    failures++;
    finish_test();
  end
endmodule
